/* hw/sarc_pkg.sv */
`default_nettype none
package sarc_pkg;
    // result and timing
    localparam int RES_W = 12;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] MSB_IDX = 4'hb;
    localparam logic [IDX_W-1:0] SHORT_LAST_IDX = 4'h4;
    localparam logic [IDX_W-1:0] SHORT_MARK_IDX = 4'h3;
    localparam int CLK_NS = 20;
    localparam int STEP_NS = 1000;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int LEAD_NS = 300;
    localparam int LEAD_CYC = LEAD_NS / CLK_NS;
    localparam int CNT_W = 8;

    // ahb-lite register map
    localparam int ABUS_W = 8;
    localparam int DBUS_W = 32;
    localparam logic [ABUS_W-1:0] REG_SAMPLE = 8'h00;
    localparam logic [ABUS_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ABUS_W-1:0] REG_RESULT = 8'h08;
    localparam logic [ABUS_W-1:0] REG_COUNT = 8'h0c;
    localparam logic [ABUS_W-1:0] REG_PINS = 8'h10;
    localparam logic [RES_W-1:0] SAMPLE_RST = 12'h000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SHORT_BIT = 1;
    localparam int ST_READ_BIT = 2;
    localparam int ST_RESULT_SHORT_BIT = 3;

    // pin vector layout
    localparam int PIN_W = 5;
    localparam int PIN_CE = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_RC = 2;
    localparam int PIN_WORD = 3;
    localparam int PIN_BYTE = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_LEAD = 3'b100
    } sarc_state_e;

    typedef enum logic [3:0] {
        VIEW_NONE = 4'b0001,
        VIEW_WORD = 4'b0010,
        VIEW_HI = 4'b0100,
        VIEW_LO = 4'b1000
    } sarc_view_e;
endpackage
`default_nettype wire

/* hw/sarc_sar_if.sv */
`default_nettype none
interface sarc_sar_if;
    import sarc_pkg::*;
    logic step;
    logic start;
    logic short_len;
    logic [RES_W-1:0] sample;
    logic busy;
    logic done;
    logic [RES_W-1:0] result;

    modport ctrl (output step, output start, output short_len, output sample,
        input busy, input done, input result);
    modport core (input step, input start, input short_len, input sample,
        output busy, output done, output result);
endinterface
`default_nettype wire

/* hw/sarc_sar_core.sv */
`default_nettype none
module sarc_sar_core (
    input wire logic clk,
    input wire logic resetn,
    sarc_sar_if.core sar
);
    import sarc_pkg::*;

    logic [RES_W-1:0] sar_ff;
    logic [IDX_W-1:0] idx_ff;
    logic busy_ff;
    logic done_ff;
    logic [RES_W-1:0] decided;

    function automatic logic [RES_W-1:0] bit_mask(input logic [IDX_W-1:0] idx);
        bit_mask = 12'h001 << idx;
    endfunction

    // trial bit stays set while it does not exceed the sampled input
    always_comb begin
        if (sar_ff <= sar.sample) begin
            decided = sar_ff;
        end else begin
            decided = sar_ff & ~bit_mask(idx_ff);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sar_ff <= '0;
            idx_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (sar.start && !busy_ff) begin // [RQ11]
                sar_ff <= bit_mask(MSB_IDX);
                idx_ff <= MSB_IDX;
                busy_ff <= 1'b1;
            end else if (busy_ff && sar.step) begin // [RQ24]
                if (idx_ff == '0) begin
                    sar_ff <= decided;
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else if (sar.short_len && idx_ff == SHORT_LAST_IDX) begin
                    // lower bits are still clear, the next trial bit stays one
                    sar_ff <= decided | bit_mask(SHORT_MARK_IDX); // [RQ2] [RQ24]
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    sar_ff <= decided | bit_mask(idx_ff - 4'h1);
                    idx_ff <= idx_ff - 4'h1;
                end
            end
        end
    end

    assign sar.busy = busy_ff;
    assign sar.done = done_ff;
    assign sar.result = sar_ff;
endmodule
`default_nettype wire

/* hw/sarc_top.sv */
// How it works
// RQ1: each start captures byte select; low means 12-bit, high means 8-bit.
// RQ2: a full word read after short conversion shows 1000 in low nibble.
// RQ3: only byte select is latched; all other controls act on live level.
// RQ4: start needs enable high, select low, read/convert low; any edge triggers.
// RQ5: enable low or select high blocks every operation.
// RQ6: the last qualifying input starts conversion, same delay from each.
// RQ7: all three qualifying inputs changing together still start a conversion.
// RQ8: host sets the two other qualifiers at least 50 ns early.
// RQ9: status is high only while a conversion runs.
// RQ10: while status is high all data outputs float and reads are refused.
// RQ11: a further start during conversion neither resets nor restarts it.
// RQ12: a further start during conversion still recaptures byte select.
// RQ13: outputs enable only with read high, status low, enable high, select low.
// RQ14: word select high drives all 12 lines and ignores byte select.
// RQ15: word select low, byte select low drives the 8 upper result bits.
// RQ16: byte select high floats top 4, zeroes bits 4-7, drives low nibble.
// RQ17: one byte is switched off before the other byte is switched on.
// RQ18: byte select may toggle any time without harm.
// RQ19: on an 8-bit bus the host wires byte select to address bit 0.
// RQ20: full conversion takes 12 us typical, 9 to 15 us.
// RQ21: short conversion takes 8 us typical, 6 to 10 us.
// RQ22: result is valid 100 to 600 ns before status falls, 300 typical.
// RQ23: stand-alone: tie enable and word high, select and byte low.
// RQ24: one decision per oscillator step, msb first, stop after 8 if short.
// RQ25: all control pins pass a two-stage synchroniser before use.
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`default_nettype none
module sarc_top #(
    parameter int STEP_CYCLES = sarc_pkg::STEP_CYC,
    parameter int LEAD_CYCLES = sarc_pkg::LEAD_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    // control pins, asynchronous
    input wire logic ce,
    input wire logic cs_n,
    input wire logic rc,
    input wire logic word_sel,
    input wire logic byte_select_short_cycle,
    // status and three-state data pins
    output logic status,
    output logic [sarc_pkg::RES_W-1:0] data_out,
    output logic [sarc_pkg::RES_W-1:0] data_oe,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [sarc_pkg::ABUS_W-1:0] haddr,
    input wire logic hwrite,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [sarc_pkg::DBUS_W-1:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [sarc_pkg::DBUS_W-1:0] hrdata
);
    import sarc_pkg::*;

    sarc_sar_if sar ();

    sarc_sar_core u_core (
        .clk(clk),
        .resetn(resetn),
        .sar(sar)
    );

    // ---------------- pin synchroniser
    logic [PIN_W-1:0] pin_a_ff;
    logic [PIN_W-1:0] pin_b_ff;
    logic ce_s;
    logic cs_n_s;
    logic rc_s;
    logic word_s;
    logic byte_s;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_a_ff <= '0;
            pin_b_ff <= '0;
        end else begin
            pin_a_ff <= {byte_select_short_cycle, word_sel, rc, cs_n, ce}; // [RQ25]
            pin_b_ff <= pin_a_ff; // [RQ25]
        end
    end

    assign ce_s = pin_b_ff[PIN_CE];
    assign cs_n_s = pin_b_ff[PIN_CS_N];
    assign rc_s = pin_b_ff[PIN_RC];
    assign word_s = pin_b_ff[PIN_WORD];
    assign byte_s = pin_b_ff[PIN_BYTE];

    // ---------------- start detection
    logic start_cond;
    logic start_cond_ff;
    logic start_evt;

    // a qualifier that is not in its state keeps the condition false
    assign start_cond = ce_s && !cs_n_s && !rc_s; // [RQ4] [RQ5] [RQ3]
    // one rising edge of the combined term, whichever input came last
    assign start_evt = start_cond && !start_cond_ff; // [RQ6] [RQ7]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            start_cond_ff <= 1'b0;
        end else begin
            start_cond_ff <= start_cond;
        end
    end

    // ---------------- conversion length latch
    logic short_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            short_ff <= 1'b0;
        end else if (start_evt) begin
            // also taken while busy, which may change the running length
            short_ff <= byte_s; // [RQ1] [RQ12]
        end
    end

    // ---------------- software registers
    logic [RES_W-1:0] sample_reg_ff;
    logic [RES_W-1:0] sample_ff;
    logic [RES_W-1:0] result_ff;
    logic result_short_ff;
    logic [CNT_W-1:0] count_ff;

    // ---------------- oscillator divider
    logic [15:0] div_ff;
    logic step_en;

    assign step_en = (div_ff == 16'(STEP_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_ff <= '0;
        end else if (sar.start || step_en) begin // [RQ11]
            // restart only on an accepted start; a refused one keeps the step phase
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    // ---------------- conversion sequencer
    sarc_state_e state_ff;
    sarc_state_e nxt_state;
    logic [15:0] lead_ff;
    logic lead_end;

    assign lead_end = (lead_ff == 16'(LEAD_CYCLES - 1));

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start_evt) begin
                    nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                // further starts are ignored here
                if (sar.done) begin // [RQ11]
                    nxt_state = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (lead_end) begin // [RQ22]
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lead_ff <= '0;
        end else if (state_ff == ST_LEAD) begin
            lead_ff <= lead_ff + 16'h0001;
        end else begin
            lead_ff <= '0;
        end
    end

    // steps of 1 us give 12 us full and 8 us short, plus the data lead
    assign sar.step = step_en && (state_ff == ST_CONV); // [RQ20] [RQ21]
    assign sar.start = start_evt && (state_ff == ST_IDLE); // [RQ11]
    assign sar.short_len = short_ff; // [RQ24]
    assign sar.sample = sample_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sample_ff <= SAMPLE_RST;
        end else if (start_evt && state_ff == ST_IDLE) begin
            sample_ff <= sample_reg_ff;
        end
    end

    // result becomes valid a fixed lead before status falls
    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_ff <= '0;
            result_short_ff <= 1'b0;
            count_ff <= '0;
        end else if (sar.done) begin
            result_ff <= sar.result; // [RQ22] [RQ2]
            result_short_ff <= short_ff;
            count_ff <= count_ff + 8'h01;
        end
    end

    // ---------------- status pin
    logic status_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_ff <= 1'b0;
        end else begin
            status_ff <= (nxt_state != ST_IDLE); // [RQ9]
        end
    end

    assign status = status_ff;

    // ---------------- output buffers
    logic read_en;
    sarc_view_e want_view;
    sarc_view_e view_ff;
    sarc_view_e nxt_view;
    logic [RES_W-1:0] data_out_ff;
    logic [RES_W-1:0] data_oe_ff;

    assign read_en = rc_s && !status_ff && ce_s && !cs_n_s; // [RQ13] [RQ10] [RQ3]

    always_comb begin
        if (!read_en) begin
            want_view = VIEW_NONE; // [RQ10] [RQ5]
        end else if (word_s) begin
            want_view = VIEW_WORD; // [RQ14]
        end else if (!byte_s) begin
            want_view = VIEW_HI; // [RQ15]
        end else begin
            want_view = VIEW_LO; // [RQ16]
        end
    end

    // a change between two driving views passes through one idle cycle
    always_comb begin
        if (want_view == view_ff || want_view == VIEW_NONE || view_ff == VIEW_NONE) begin
            nxt_view = want_view;
        end else begin
            nxt_view = VIEW_NONE; // [RQ17] [RQ18]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            view_ff <= VIEW_NONE;
        end else begin
            view_ff <= nxt_view;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_out_ff <= '0;
            data_oe_ff <= '0;
        end else begin
            unique case (nxt_view)
                VIEW_WORD: begin
                    data_out_ff <= result_ff; // [RQ14]
                    data_oe_ff <= 12'hfff;
                end
                VIEW_HI: begin
                    data_out_ff <= {result_ff[11:4], 4'h0}; // [RQ15]
                    data_oe_ff <= 12'hff0;
                end
                VIEW_LO: begin
                    data_out_ff <= {4'h0, 4'h0, result_ff[3:0]}; // [RQ16]
                    data_oe_ff <= 12'h0ff;
                end
                default: begin
                    data_out_ff <= '0;
                    data_oe_ff <= '0;
                end
            endcase
        end
    end

    assign data_out = data_out_ff;
    assign data_oe = data_oe_ff;

    // ---------------- ahb-lite slave, zero wait states
    logic addr_valid;
    logic dp_write_ff;
    logic [ABUS_W-1:0] dp_addr_ff;
    logic [DBUS_W-1:0] hrdata_ff;
    logic sample_wr;

    assign addr_valid = hsel && hready && htrans[1];
    assign sample_wr = dp_write_ff && (dp_addr_ff == REG_SAMPLE);

    function automatic logic [DBUS_W-1:0] read_mux(input logic [ABUS_W-1:0] addr,
            input logic [RES_W-1:0] samp);
        logic [DBUS_W-1:0] val;
        val = '0;
        unique case (addr)
            REG_SAMPLE: val[RES_W-1:0] = samp;
            REG_STATUS: begin
                val[ST_BUSY_BIT] = status_ff;
                val[ST_SHORT_BIT] = short_ff;
                val[ST_READ_BIT] = read_en;
                val[ST_RESULT_SHORT_BIT] = result_short_ff;
            end
            REG_RESULT: val[RES_W-1:0] = result_ff;
            REG_COUNT: val[CNT_W-1:0] = count_ff;
            REG_PINS: val[PIN_W-1:0] = pin_b_ff;
            default: val = '0;
        endcase
        read_mux = val;
    endfunction

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dp_write_ff <= 1'b0;
            dp_addr_ff <= '0;
        end else if (hready) begin
            dp_write_ff <= addr_valid && hwrite;
            dp_addr_ff <= haddr;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sample_reg_ff <= SAMPLE_RST;
        end else if (sample_wr) begin
            sample_reg_ff <= hwdata[RES_W-1:0];
        end
    end

    // read data is fetched in the address phase; a write still in its data
    // phase to the same word is forwarded
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hrdata_ff <= '0;
        end else if (addr_valid && !hwrite) begin
            if (sample_wr) begin
                hrdata_ff <= read_mux(haddr, hwdata[RES_W-1:0]);
            end else begin
                hrdata_ff <= read_mux(haddr, sample_reg_ff);
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY[0];
    assign hrdata = hrdata_ff;
endmodule
`default_nettype wire

/* test/sarc_properties.sv */
`default_nettype none
module sarc_properties #(
    parameter int STEP_CYCLES = sarc_pkg::STEP_CYC,
    parameter int LEAD_CYCLES = sarc_pkg::LEAD_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic rc,
    input wire logic status,
    input wire logic [sarc_pkg::RES_W-1:0] data_out,
    input wire logic [sarc_pkg::RES_W-1:0] data_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    import sarc_pkg::*;
    // cycles spent with status high in the current conversion
    logic [11:0] run_ff;
    always_ff @(posedge clk) begin
        if (!resetn || !status) begin
            run_ff <= 12'h000;
        end else begin
            run_ff <= run_ff + 12'h001;
        end
    end
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_float_busy: assert property (status |-> data_oe == 12'h000)
        else $error("data outputs driven while converting");
    a_view_legal: assert property (data_oe inside {12'h000, 12'hfff, 12'hff0, 12'h0ff})
        else $error("output enable pattern not a legal view");
    a_lo_nibble: assert property (data_oe == 12'h0ff |-> data_out[7:4] == 4'h0)
        else $error("bits 4 to 7 not zero in low byte view");
    a_break_make: assert property (
        data_oe != 12'h000 && $past(data_oe) != 12'h000 |-> data_oe == $past(data_oe))
        else $error("views switched without a gap");
    a_hold_ce: assert property ((!ce)[*8] |-> data_oe == 12'h000 && !$rose(status))
        else $error("activity while enable low");
    a_hold_cs: assert property (cs_n[*8] |-> data_oe == 12'h000 && !$rose(status))
        else $error("activity while not selected");
    a_read_needs_rc: assert property ((!rc)[*8] |-> data_oe == 12'h000)
        else $error("outputs driven in convert mode");
    a_start_answer: assert property (
        $rose(ce && !cs_n && !rc) && !status |-> ##[1:8] status)
        else $error("start not answered by status");
    a_conv_length: assert property (
        $fell(status) |-> run_ff >= 8 * STEP_CYCLES
            && run_ff <= 12 * STEP_CYCLES + LEAD_CYCLES + 4)
        else $error("conversion length out of range");
endmodule
bind sarc_top sarc_properties #(.STEP_CYCLES(STEP_CYCLES), .LEAD_CYCLES(LEAD_CYCLES)) u_props (
    .clk(clk), .resetn(resetn), .ce(ce), .cs_n(cs_n), .rc(rc), .status(status),
    .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

/* test/sarc_host_model.sv */
`default_nettype none
module sarc_host_model (
    input wire logic clk,
    output logic ce,
    output logic cs_n,
    output logic rc,
    output logic word_sel,
    output logic byte_select_short_cycle
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ce = 1'b1;
        cs_n = 1'b1;
        rc = 1'b1;
        word_sel = 1'b1;
        byte_select_short_cycle = 1'b0;
    end
    // pins change right after an edge and hold at least one cycle
    task automatic drive(input logic c, input logic s, input logic r, input logic w,
            input logic b);
        ce <= c;
        cs_n <= s;
        rc <= r;
        word_sel <= w;
        byte_select_short_cycle <= b;
        @(posedge clk);
    endtask
    // kind names the last qualifier: 0 enable, 1 select, 2 read/convert, 3 all together
    task automatic convert(input int kind, input logic sh, input int setup);
        drive(!(kind == 0 || kind == 3), kind == 1 || kind == 3, kind >= 2, word_sel, sh);
        repeat (setup) @(posedge clk);
        drive(1'b1, 1'b0, 1'b0, word_sel, sh);
        repeat (6) @(posedge clk);
        drive(1'b1, 1'b1, 1'b1, word_sel, sh);
    endtask
    // byte select stands in for the lowest address bit of a byte bus
    task automatic read(input logic c, input logic s, input logic w, input logic b);
        drive(c, s, 1'b1, w, b);
        repeat (5) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* test/sar_adc_bus_control_test.sv */
`default_nettype none
module sar_adc_bus_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sarc_pkg::*;
    typedef struct packed {
        logic pin;
        logic [31:0] val;
    } sarc_note_s;
    logic clk, resetn, ce, cs_n, rc, word_sel, byte_select_short_cycle, status;
    logic hsel, hwrite, hreadyout, hresp, rd_phase, pin_chk;
    logic [RES_W-1:0] data_out, data_oe;
    logic [ABUS_W-1:0] haddr;
    logic [1:0] htrans;
    logic [DBUS_W-1:0] hwdata, hrdata;
    int failures, cmp_count;
    sarc_note_s notes[$];

    sarc_top #(.STEP_CYCLES(4), .LEAD_CYCLES(2)) DUT (
        .clk(clk), .resetn(resetn), .ce(ce), .cs_n(cs_n), .rc(rc), .word_sel(word_sel),
        .byte_select_short_cycle(byte_select_short_cycle), .status(status),
        .data_out(data_out), .data_oe(data_oe), .hsel(hsel), .haddr(haddr),
        .hwrite(hwrite), .htrans(htrans), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    sarc_host_model host (.clk(clk), .ce(ce), .cs_n(cs_n), .rc(rc), .word_sel(word_sel),
        .byte_select_short_cycle(byte_select_short_cycle));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check_bus(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic check_pins(input logic [23:0] e, input logic [23:0] s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("ERROR data_oe_data_out expected %h seen %h", e, s);
        end
    endtask
    always @(posedge clk) begin : watch
        sarc_note_s n;
        if ((rd_phase === 1'b1 && hreadyout === 1'b1) || pin_chk === 1'b1) begin
            n = notes.pop_front();
            if (n.pin)
                check_pins(n.val[23:0], {data_oe, data_out});
            else begin
                check_bus("hrdata", n.val, hrdata);
                check_bus("hresp", {31'h0, HRESP_OKAY[0]}, {31'h0, hresp});
            end
        end
    end

    task automatic ahb_addr(input logic [7:0] a, input logic w);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
    endtask
    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        ahb_addr(a, 1'b1);
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic ahb_read(input logic [7:0] a, input logic [31:0] e);
        notes.push_back({1'b0, e});
        ahb_addr(a, 1'b0);
        rd_phase <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
    endtask
    task automatic pin_read(input logic c, input logic s, input logic w, input logic b,
            input logic [23:0] e);
        notes.push_back({1'b1, 8'h00, e});
        host.read(c, s, w, b);
        pin_chk <= 1'b1;
        @(posedge clk);
        pin_chk <= 1'b0;
    endtask
    function automatic logic [23:0] view(input logic w, input logic b, input logic [11:0] r);
        if (w)
            return {12'hfff, r};
        if (!b)
            return {12'hff0, r[11:4], 4'h0};
        return {12'h0ff, 8'h00, r[3:0]};
    endfunction
    task automatic wait_idle();
        int k;
        for (k = 0; k < 300 && status !== 1'b0; k++) @(posedge clk);
        if (status !== 1'b0) begin
            failures++;
            $display("ERROR status expected 0 seen %b", status);
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin : main
        logic [11:0] s;
        logic [11:0] r;
        logic sh;
        logic b;
        int i;
        int nconv;
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        hwrite = 1'b0;
        htrans = 2'h0;
        hwdata = 32'h0;
        rd_phase = 1'b0;
        pin_chk = 1'b0;
        failures = 0;
        cmp_count = 0;
        nconv = 0;
        void'($urandom(99546));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        ahb_read(REG_SAMPLE, {20'h0, SAMPLE_RST});
        ahb_read(REG_STATUS, 32'h0);
        ahb_read(8'h14, 32'h0);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            s = 12'($urandom());
            sh = i[2];
            r = sh ? {s[11:4], 4'h8} : s;
            ahb_write(REG_SAMPLE, {20'h0, s});
            host.convert(i % 4, sh, 2 + i % 3);
            repeat (3) host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'($urandom()));
            wait_idle();
            nconv++;
            b = 1'($urandom());
            pin_read(1'b1, 1'b0, 1'b1, b, view(1'b1, b, r));
            pin_read(1'b1, 1'b0, 1'b0, 1'b0, view(1'b0, 1'b0, r));
            pin_read(1'b1, 1'b0, 1'b0, 1'b1, view(1'b0, 1'b1, r));
            host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
            ahb_read(REG_RESULT, {20'h0, r});
        end
        ahb_read(REG_COUNT, 32'(nconv));
        $display("test conversions done");
        for (i = 0; i < 2; i++) begin
            s = 12'($urandom());
            r = i[0] ? {s[11:4], 4'h8} : s;
            ahb_write(REG_SAMPLE, {20'h0, s});
            host.convert(2, 1'b0, 2);
            host.convert(2, i[0], 2);
            wait_idle();
            nconv++;
            ahb_read(REG_RESULT, {20'h0, r});
            ahb_read(REG_COUNT, 32'(nconv));
        end
        $display("test restart done");
        for (i = 0; i < 2; i++) begin
            host.drive(i[0], i[0], 1'b0, 1'b1, 1'b0);
            repeat (10) @(posedge clk);
            pin_read(i[0], i[0], 1'b1, 1'b0, 24'h0);
        end
        host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        ahb_read(REG_COUNT, 32'(nconv));
        $display("test hold off done");
        give_verdict();
    end
endmodule
`default_nettype wire
